// ===== verilog/pta_tx_slot.sv
// PCM highway transmit time-slot assigner with AHB-Lite registers
//
// Added by the designer: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pta_defs.svh"
module pta_tx_slot
	import pta_pkg::*;
(
	input  wire logic        i_clk,                  // 200 MHz clock
	input  wire logic        i_sys_rst,              // Sync reset, high
	input  wire logic        hsel,                   // AHB select
	input  wire logic [31:0] haddr,                  // AHB address
	input  wire logic [1:0]  htrans,                 // AHB transfer type
	input  wire logic        hwrite,                 // AHB write
	input  wire logic [2:0]  hsize,                  // AHB size
	input  wire logic [31:0] hwdata,                 // AHB write data
	input  wire logic        hready,                 // AHB bus ready
	output logic             hreadyout,              // AHB slave ready
	output logic             hresp,                  // AHB response
	output logic      [31:0] hrdata,                 // AHB read data
	input  wire logic        i_bit_clk,              // Highway bit clock pin
	input  wire logic        i_frame_sync,           // Frame sync pin
	input  wire logic        i_hw_rst_n,             // Hardware reset pin
	input  wire logic        i_group_cs_n,           // Group chip select
	input  wire logic        i_control_serial_clock, // Control clock pin
	input  wire logic        i_mux_mode,             // Multiplexed mode strap
	input  wire logic [63:0] i_tx_sample,            // Samples, ch0 low
	input  wire logic [31:0] i_sig_byte,             // Signaling, ch0 low
	output logic             o_tx_port_a,            // Port A data
	output logic             o_tx_port_a_oe,         // Port A drive
	output logic             o_tx_port_b,            // Port B data
	output logic             o_tx_port_b_oe,         // Port B drive
	output logic             o_slot_drive_ind_a_n,   // Port A indicator
	output logic             o_slot_drive_ind_b_n,   // Port B indicator
	output logic [3:0]       o_channel_active_flag   // Active channels
);
	localparam int NCH = `PTA_NCH;

	logic [5:0]  pin_s;
	logic        bclk_s, fs_s, hwrst_n_s, cs_n_s, control_serial_clock_s, mux_s;
	logic        bclk_d1_q, control_serial_clock_d1_q;
	logic        rise_e, fall_e, upd_e;
	logic        dev_rst, grp_rst;
	logic [4:0]  cs_cnt_q;
	pta_ctrl_s   ctrl_q;
	pta_ch_cfg_s cfg_q [NCH];
	logic [3:0]  chen_q;
	logic [3:0]  act_q;
	logic [15:0] snap_q [NCH];
	logic [7:0]  sigb_q [NCH];
	logic [15:0] rdbk_q;
	logic [10:0] bit_cnt_q;
	logic [10:0] frame_len_q;
	logic [10:0] npos;
	logic        lin_eff;
	logic [NCH-1:0] drv_a, drv_b, bit_v;
	logic        tx_a_d, tx_b_d;
	logic        we_q;
	logic [7:0]  aw_q;
	logic        acc;
	logic        cmd_we;
	logic [7:0]  cmd_op;
	logic [1:0]  cmd_ch;

	pta_sync #(.W(6)) u_sync (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_rst_val (6'h0c),
		.i_async   ({i_mux_mode, i_control_serial_clock, i_group_cs_n,
		              i_hw_rst_n, i_frame_sync, i_bit_clk}),
		.o_sync    (pin_s)
	);
	assign bclk_s    = pin_s[0];
	assign fs_s      = pin_s[1];
	assign hwrst_n_s = pin_s[2];
	assign cs_n_s    = pin_s[3];
	assign control_serial_clock_s    = pin_s[4];
	assign mux_s     = pin_s[5];

	// Edge detectors read the second flop only
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			bclk_d1_q <= 1'b0;
			control_serial_clock_d1_q <= 1'b0;
		end else begin
			bclk_d1_q <= bclk_s;
			control_serial_clock_d1_q <= control_serial_clock_s;
		end
	end
	assign rise_e = bclk_s & ~bclk_d1_q;
	assign fall_e = ~bclk_s & bclk_d1_q;
	assign upd_e  = ctrl_q.tx_rise ? rise_e : fall_e;

	// Group reset: select held low across 16 control clock rises
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || cs_n_s) begin
			cs_cnt_q <= 5'h00;
		end else if (control_serial_clock_s && !control_serial_clock_d1_q && cs_cnt_q != `PTA_CS_RST_EDGES) begin
			cs_cnt_q <= cs_cnt_q + 5'h01;
		end
	end
	assign grp_rst = (cs_cnt_q == `PTA_CS_RST_EDGES);

	// Synced reset pin and select idle high, so no extra reset follows
	assign dev_rst = i_sys_rst | ~hwrst_n_s | grp_rst
		| (cmd_we && cmd_op == `PTA_CMD_HWRESET);

	// AHB-Lite: zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign acc       = hsel & hready & htrans[1];
	assign cmd_we    = we_q && aw_q == `PTA_CMD_OFF;
	assign cmd_op    = hwdata[7:0];
	assign cmd_ch    = hwdata[9:8];

	function automatic logic [31:0] rd_mux(input logic [7:0] a);
		logic [31:0] r;
		int k;
		r = 32'h0;
		case (a)
			`PTA_CTRL_OFF: r = {21'h0, ctrl_q};
			`PTA_CHEN_OFF: r = {28'h0, chen_q};
			`PTA_STAT_OFF: r = {13'h0, frame_len_q, 3'h0, mux_s, act_q};
			`PTA_RDBK_OFF: r = {16'h0, rdbk_q};
			default: begin
				for (k = 0; k < NCH; k++) begin
					if (a == `PTA_CFG_OFF + 8'(4 * k)) begin
						r = {18'h0, cfg_q[k].port_b, cfg_q[k].port_a,
							1'b0, cfg_q[k].clk_slot, 1'b0, cfg_q[k].slot};
					end
				end
			end
		endcase
		return r;
	endfunction

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			we_q <= 1'b0;
			aw_q <= 8'h00;
		end else begin
			we_q <= acc & hwrite;
			aw_q <= {haddr[7:2], 2'b00};
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			hrdata <= 32'h0;
		end else if (acc && !hwrite) begin
			hrdata <= rd_mux({haddr[7:2], 2'b00});
		end
	end

	// Control and channel enable registers
	always_ff @(posedge i_clk) begin
		if (dev_rst) begin
			ctrl_q.ulaw     <= 1'b0;
			ctrl_q.test     <= 4'h0;
			ctrl_q.linear   <= 1'b0;
			ctrl_q.sig_mode <= 1'b0;
			ctrl_q.tx_rise  <= 1'b0;
			ctrl_q.mclk_sel <= `PTA_MCLK_8192;
			chen_q          <= `PTA_CHEN_RST;
		end else if (we_q && aw_q == `PTA_CTRL_OFF) begin
			ctrl_q <= hwdata[10:0];
		end else if (we_q && aw_q == `PTA_CHEN_OFF) begin
			chen_q <= hwdata[3:0];
		end
	end

	// Channel state follows commands
	always_ff @(posedge i_clk) begin
		if (dev_rst) begin
			act_q <= 4'h0;
		end else if (cmd_we && cmd_op == `PTA_CMD_ACT) begin
			act_q <= act_q | chen_q;
		end else if (cmd_we && (cmd_op == `PTA_CMD_DEACT
				|| cmd_op == `PTA_CMD_SOFTRST)) begin
			act_q <= act_q & ~chen_q;
		end
	end
	assign o_channel_active_flag = act_q;

	always_ff @(posedge i_clk) begin
		if (dev_rst) begin
			rdbk_q <= 16'h0;
		end else if (cmd_we && cmd_op == `PTA_CMD_RDSAMP) begin
			rdbk_q <= snap_q[cmd_ch];
		end
	end

	// Frame position counter in bit clock periods
	always_ff @(posedge i_clk) begin
		if (dev_rst) begin
			bit_cnt_q   <= 11'h0;
			frame_len_q <= 11'h0;
		end else if (upd_e) begin
			bit_cnt_q <= npos;
			if (fs_s) begin
				frame_len_q <= bit_cnt_q + 11'h1;
			end
		end
	end
	assign npos = fs_s ? 11'h0 : bit_cnt_q + 11'h1;

	// Linear not offered in the multiplexed interface mode
	assign lin_eff = ctrl_q.linear & ~mux_s;

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			logic [10:0] base, d;
			logic [7:0]  last_b;
			logic [2:0]  rem;
			logic [15:0] word;
			logic        wide, in_win, frac;

			always_ff @(posedge i_clk) begin
				if (dev_rst) begin
					cfg_q[g].slot     <= 7'(g);
					cfg_q[g].clk_slot <= 3'h0;
					cfg_q[g].port_a   <= 1'b1;
					cfg_q[g].port_b   <= 1'b0;
				end else if (we_q && aw_q == `PTA_CFG_OFF + 8'(4 * g)) begin
					cfg_q[g].slot     <= hwdata[6:0];
					cfg_q[g].clk_slot <= hwdata[10:8];
					cfg_q[g].port_a   <= hwdata[12];
					cfg_q[g].port_b   <= hwdata[13];
				end
			end

			// Sample is frozen per frame; a slot at position 0 takes its first bit from the previous frame's sample
			always_ff @(posedge i_clk) begin
				if (dev_rst) begin
					snap_q[g] <= 16'h0;
					sigb_q[g] <= 8'h0;
				end else if (upd_e && fs_s) begin
					snap_q[g] <= i_tx_sample[16*g +: 16];
					sigb_q[g] <= i_sig_byte[8*g +: 8];
				end
			end

			assign base   = {1'b0, cfg_q[g].slot, 3'b000}
				+ {8'h00, cfg_q[g].clk_slot};
			assign d      = npos - base;
			assign wide   = lin_eff | ctrl_q.sig_mode;
			assign word   = lin_eff ? snap_q[g]
				: {snap_q[g][7:0], ctrl_q.sig_mode ? sigb_q[g] : 8'h00};
			assign in_win = (npos >= base)
				&& (d < (wide ? 11'd16 : 11'd8));
			assign rem    = frame_len_q[2:0];
			assign last_b = frame_len_q[10:3] - 8'h01;
			assign frac   = (rem != 3'h0) && (cfg_q[g].clk_slot > rem)
				&& ({1'b0, cfg_q[g].slot} == last_b)
				&& (npos >= frame_len_q - {8'h00, rem})
				&& (npos < frame_len_q);
			assign bit_v[g] = word[4'hf - d[3:0]];
			assign drv_a[g] = act_q[g] & cfg_q[g].port_a & (in_win | frac);
			assign drv_b[g] = act_q[g] & cfg_q[g].port_b & (in_win | frac);
		end
	endgenerate

	// Lowest channel wins if two are mis-programmed onto one slot
	always_comb begin
		tx_a_d = 1'b0;
		tx_b_d = 1'b0;
		for (int k = NCH - 1; k >= 0; k--) begin
			if (drv_a[k]) begin
				tx_a_d = bit_v[k];
			end
			if (drv_b[k]) begin
				tx_b_d = bit_v[k];
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (dev_rst) begin
			o_tx_port_a    <= 1'b0;
			o_tx_port_b    <= 1'b0;
			o_tx_port_a_oe <= 1'b0;
			o_tx_port_b_oe <= 1'b0;
		end else if (upd_e) begin
			o_tx_port_a    <= tx_a_d;
			o_tx_port_b    <= tx_b_d;
			o_tx_port_a_oe <= |drv_a;
			o_tx_port_b_oe <= |drv_b;
		end
	end
	assign o_slot_drive_ind_a_n = ~o_tx_port_a_oe;
	assign o_slot_drive_ind_b_n = ~o_tx_port_b_oe;

	a_ind_tracks_drive: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		o_slot_drive_ind_a_n == !o_tx_port_a_oe
		&& o_slot_drive_ind_b_n == !o_tx_port_b_oe)
		else $error("indicator differs from drive");

	a_standby_quiet: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		upd_e && act_q == 4'h0 |=> !o_tx_port_a_oe && !o_tx_port_b_oe)
		else $error("standby channels drive the highway");

	a_frame_zero: assert property (
		@(posedge i_clk) disable iff (dev_rst)
		upd_e && fs_s |=> bit_cnt_q == 11'h0)
		else $error("frame sync did not restart slot zero");

	a_bit_advance: assert property (
		@(posedge i_clk) disable iff (dev_rst)
		upd_e && !fs_s |=> bit_cnt_q == $past(bit_cnt_q) + 11'h1)
		else $error("bit position did not advance");

	a_out_hold: assert property (
		@(posedge i_clk) disable iff (dev_rst)
		!upd_e |=> $stable(o_tx_port_a) && $stable(o_tx_port_a_oe))
		else $error("port changed away from chosen edge");

	a_reset_defaults: assert property (
		@(posedge i_clk)
		$past(i_sys_rst) |-> !ctrl_q.ulaw && ctrl_q.test == 4'h0
		&& ctrl_q.mclk_sel == `PTA_MCLK_8192 && !ctrl_q.tx_rise)
		else $error("control defaults wrong after reset");

	a_chan_defaults: assert property (
		@(posedge i_clk)
		$past(i_sys_rst) |-> act_q == 4'h0 && chen_q == 4'hf
		&& !ctrl_q.sig_mode)
		else $error("channel defaults wrong after reset");

	a_slot_defaults: assert property (
		@(posedge i_clk)
		$past(i_sys_rst) |-> cfg_q[3].slot == 7'h3
		&& cfg_q[1].slot == 7'h1 && cfg_q[2].clk_slot == 3'h0
		&& cfg_q[0].port_a && !cfg_q[0].port_b)
		else $error("slot defaults wrong after reset");

	a_linear_gated: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		mux_s |-> !lin_eff)
		else $error("linear coding in multiplexed mode");

	a_activate_sel: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		!dev_rst && cmd_we && cmd_op == `PTA_CMD_ACT
		|=> act_q == ($past(act_q) | $past(chen_q)))
		else $error("activate touched unselected channels");

	a_readback: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		!dev_rst && cmd_we && cmd_op == `PTA_CMD_RDSAMP
		|=> rdbk_q == $past(snap_q[cmd_ch]))
		else $error("readback not loaded with sample");

	a_group_reset: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		grp_rst |=> act_q == 4'h0 && chen_q == 4'hf)
		else $error("group reset did not restore defaults");

endmodule // pta_tx_slot
`default_nettype wire

// ===== shared/pta_defs.svh
// Constants of the PCM transmit slot assigner
`ifndef PTA_DEFS_SVH
`define PTA_DEFS_SVH

`define PTA_NCH          4
`define PTA_CTRL_OFF     8'h00
`define PTA_CHEN_OFF     8'h04
`define PTA_CMD_OFF      8'h08
`define PTA_STAT_OFF     8'h0c
`define PTA_RDBK_OFF     8'h10
`define PTA_CFG_OFF      8'h20
`define PTA_CMD_DEACT    8'h00
`define PTA_CMD_SOFTRST  8'h02
`define PTA_CMD_HWRESET  8'h04
`define PTA_CMD_ACT      8'h0e
`define PTA_CMD_RDSAMP   8'hcd
`define PTA_MCLK_8192    3'h0
`define PTA_CHEN_RST     4'hf
`define PTA_CS_RST_EDGES 5'h10
`define PTA_BCLK_MIN_KHZ 128
`define PTA_BCLK_MAX_KHZ 8192

`endif

// ===== shared/pta_pkg.sv
// Types of the PCM transmit slot assigner
package pta_pkg;

	typedef struct packed {
		logic       port_b;
		logic       port_a;
		logic [2:0] clk_slot;
		logic [6:0] slot;
	} pta_ch_cfg_s;

	typedef struct packed {
		logic [2:0] mclk_sel;
		logic [3:0] test;
		logic       tx_rise;
		logic       sig_mode;
		logic       linear;
		logic       ulaw;
	} pta_ctrl_s;

endpackage

// ===== verilog/pta_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module pta_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,     // System clock
	input  wire logic         i_sys_rst, // Synchronous reset
	input  wire logic [W-1:0] i_rst_val, // Value held in reset
	input  wire logic [W-1:0] i_async,   // Pin inputs
	output logic      [W-1:0] o_sync     // Synchronised levels
);
	logic [W-1:0] meta_q;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			meta_q <= i_rst_val;
			o_sync <= i_rst_val;
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end
endmodule // pta_sync
`default_nettype wire

// ===== verif/pta_highway_model.sv
// PCM backplane model: bit clock, frame sync, slot capture
`timescale 1ns/1ps
`default_nettype none
module pta_highway_model #(
	parameter real HALF_NS = 61.035, // 8.192 MHz highway
	parameter int FL      = 40  // Bits per frame
) (
	input  wire logic       i_rise,       // Capture on rising edge
	input  wire logic [5:0] i_lines,      // a_oe,a,ind_a,b_oe,b,ind_b
	output logic            o_bit_clk,    // Highway bit clock
	output logic            o_frame_sync, // Frame sync
	output int              o_frames      // Frames started
);
	logic [5:0] cap [0:FL-1];
	int         n;

	initial begin
		o_bit_clk = 1'b0;
		o_frame_sync = 1'b0;
		o_frames = 0;
		n = 0;
		forever #(HALF_NS) o_bit_clk = ~o_bit_clk;
	end

	// A position's bit is captured one sampling edge later, after it has settled
	always @(o_bit_clk) begin
		if (o_bit_clk == i_rise) begin
			cap[(n + FL - 1) % FL] <= i_lines;
			if (n == 0)
				o_frames <= o_frames + 1;
			n <= (n + 1) % FL;
		end else begin
			o_frame_sync <= (n == 0);
		end
	end
endmodule // pta_highway_model
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench of the PCM transmit slot assigner
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int FL = 40;
	logic        i_clk, i_sys_rst, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        bclk, fs, rise, hw_rst_n, cs_n, cclk, mux;
	logic [63:0] samp;
	logic [31:0] sig;
	logic        a, a_oe, b, b_oe, ia_n, ib_n;
	logic [3:0]  act, pa, pb, act_flag;
	logic [15:0] wd [4];
	int          st [4];
	int          ln [4];
	int          frames, bad_count, compares;

	pta_tx_slot i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .i_bit_clk(bclk),
		.i_frame_sync(fs), .i_hw_rst_n(hw_rst_n), .i_group_cs_n(cs_n),
		.i_control_serial_clock(cclk), .i_mux_mode(mux),
		.i_tx_sample(samp), .i_sig_byte(sig), .o_tx_port_a(a),
		.o_tx_port_a_oe(a_oe), .o_tx_port_b(b), .o_tx_port_b_oe(b_oe),
		.o_slot_drive_ind_a_n(ia_n), .o_slot_drive_ind_b_n(ib_n),
		.o_channel_active_flag(act_flag));
	pta_highway_model #(.FL(FL)) i_model (.i_rise(rise),
		.i_lines({a_oe, a, ia_n, b_oe, b, ib_n}), .o_bit_clk(bclk),
		.o_frame_sync(fs), .o_frames(frames));

	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic conclude;
		$display("mismatches=%0d compares=%0d", bad_count, compares);
		if (bad_count == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic ahb(input logic w, input logic [7:0] ad,
		input logic [31:0] wdat);
		int k;
		@(posedge i_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, ad};
		hwrite <= w;
		k = 0;
		do begin @(posedge i_clk); k++; end while (hreadyout !== 1'b1 && k < 64);
		htrans <= 2'h0;
		hwdata <= wdat;
		do begin @(posedge i_clk); k++; end while (hreadyout !== 1'b1 && k < 64);
		r = hrdata;
		if (k >= 64) begin
			bad_count++;
			conclude();
		end
	endtask

	task automatic rc(input logic [7:0] ad, input logic [31:0] exp);
		ahb(1'b0, ad, 32'h0);
		chk(r, exp);
		chk({31'h0, hresp}, 32'h0);
	endtask

	task automatic wait_frames(input int nf);
		int k, f0;
		repeat (nf) begin
			f0 = frames;
			k = 0;
			while (frames == f0 && k < 4000) begin @(posedge i_clk); k++; end
			if (k >= 4000) begin
				bad_count++;
				conclude();
			end
		end
	endtask

	// Mode 0 companded, 1 linear, 2 sample plus signaling byte
	task automatic set_ch(input int c, input int sl, input int off,
		input logic ea, input logic eb, input int mode);
		ahb(1'b1, 8'h20 + 8'(4 * c),
			{18'h0, eb, ea, 1'b0, 3'(off), 1'b0, 7'(sl)});
		st[c] = 8 * sl + off;
		ln[c] = (mode == 0) ? 8 : 16;
		wd[c] = (mode == 1) ? samp[16*c +: 16] :
			{samp[16*c +: 8], (mode == 2) ? sig[8*c +: 8] : 8'h00};
		pa[c] = ea;
		pb[c] = eb;
	endtask

	task automatic frame_chk;
		logic [5:0] e, s;
		int c, p, q;
		wait_frames(2);
		chk({28'h0, act_flag}, {28'h0, act});
		for (p = 0; p < FL; p++) begin
			e = 6'b001001;
			for (c = 3; c >= 0; c--) begin
				q = p - st[c];
				if (act[c] && q >= 0 && q < ln[c]) begin
					if (pa[c]) e[5:3] = {1'b1, wd[c][15-q], 1'b0};
					if (pb[c]) e[2:0] = {1'b1, wd[c][15-q], 1'b0};
				end
			end
			s = i_model.cap[p];
			s[4] = s[4] & e[5];
			s[1] = s[1] & e[2];
			chk({26'h0, s}, {26'h0, e});
		end
	endtask

	initial begin
		i_sys_rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		rise = 1'b0;
		hw_rst_n = 1'b1;
		cs_n = 1'b1;
		cclk = 1'b0;
		mux = 1'b0;
		samp = 64'h4d96_c33c_7e81_b25a;
		sig = 32'h6b2c_d4e7;
		act = 4'h0;
		bad_count = 0;
		compares = 0;
		repeat (4) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		repeat (4) @(posedge i_clk);
		rc(8'h00, 32'h0);
		rc(8'h04, 32'hf);
		for (int c = 0; c < 4; c++)
			rc(8'h20 + 8'(4 * c), 32'h1000 | c);
		ahb(1'b0, 8'h0c, 32'h0);
		chk(r & 32'h1f, 32'h0);
		rc(8'h3c, 32'h0);
		for (int c = 0; c < 4; c++)
			set_ch(c, c, 0, 1'b1, 1'b0, 0);
		frame_chk();
		ahb(1'b1, 8'h08, 32'h0e);
		act = 4'hf;
		frame_chk();
		ahb(1'b1, 8'h04, 32'he);
		ahb(1'b1, 8'h08, 32'h00);
		act = 4'h1;
		ahb(1'b0, 8'h0c, 32'h0);
		chk(r & 32'hf, 32'h1);
		chk((r >> 8) & 32'h7ff, 32'(FL));
		set_ch(0, 1, 3, 1'b0, 1'b1, 0);
		frame_chk();
		ahb(1'b1, 8'h00, 32'h2);
		set_ch(0, 1, 3, 1'b0, 1'b1, 1);
		frame_chk();
		ahb(1'b1, 8'h00, 32'h4);
		set_ch(0, 1, 3, 1'b0, 1'b1, 2);
		frame_chk();
		mux <= 1'b1;
		ahb(1'b1, 8'h00, 32'h2);
		set_ch(0, 1, 3, 1'b0, 1'b1, 0);
		frame_chk();
		mux <= 1'b0;
		rise <= 1'b1;
		ahb(1'b1, 8'h00, 32'h8);
		set_ch(0, 2, 7, 1'b1, 1'b1, 0);
		frame_chk();
		for (int c = 0; c < 4; c++) begin
			ahb(1'b1, 8'h08, {22'h0, 2'(c), 8'hcd});
			rc(8'h10, {16'h0, samp[16*c +: 16]});
		end
		ahb(1'b1, 8'h00, 32'h4);
		ahb(1'b1, 8'h08, 32'h04);
		repeat (8) @(posedge i_clk);
		rc(8'h00, 32'h0);
		ahb(1'b1, 8'h00, 32'h4);
		hw_rst_n <= 1'b0;
		repeat (4) @(posedge i_clk);
		hw_rst_n <= 1'b1;
		repeat (8) @(posedge i_clk);
		rc(8'h00, 32'h0);
		// Fifteen edges must not reset the group, sixteen must
		for (int n = 15; n < 17; n++) begin
			ahb(1'b1, 8'h00, 32'h4);
			cs_n <= 1'b0;
			repeat (n) begin
				repeat (3) @(posedge i_clk);
				cclk <= 1'b1;
				repeat (3) @(posedge i_clk);
				cclk <= 1'b0;
			end
			repeat (3) @(posedge i_clk);
			cs_n <= 1'b1;
			repeat (8) @(posedge i_clk);
			rc(8'h00, (n == 16) ? 32'h0 : 32'h4);
		end
		conclude();
	end
endmodule // tb
`default_nettype wire
